//--- nmpw_top.sv
// nmpw_top.sv: nmi source select, pin interrupt select and wake enables
`timescale 1ns/1ps
`default_nettype none
module nmpw_top
    import nmpw_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic [31:0] i_reg_addr,
    input wire logic [31:0] i_reg_wdata,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    output logic [31:0] o_reg_rdata,
    input wire logic [31:0] i_periph_irq,
    input wire logic [30:0] i_pin_in,
    input wire logic [15:0] i_wake_src,
    input wire logic i_deep_sleep,
    output logic [31:0] o_core_irq,
    output logic o_nmi,
    output logic [7:0] o_pin_chan,
    output logic o_wake_req,
    output logic o_irq
);

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------

    // pin numbers 0..5 and 7..30 exist
    function automatic logic nmpw_pin_ok(input logic [5:0] num);
        nmpw_pin_ok = (num <= NMPW_PIN_MAX) && (num != NMPW_PIN_HOLE);
    endfunction

    // word-aligned hit inside the selector window
    function automatic logic nmpw_sel_hit(input logic [31:0] addr);
        nmpw_sel_hit = (addr >= NMPW_PIN_SEL0_ADDR) && (addr <= NMPW_PIN_SEL7_ADDR)
            && (addr[1:0] == 2'b00);
    endfunction

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic [4:0] nmi_irq_number;
    logic nmi_route_enable;
    logic [5:0] pin_irq_select [NMPW_CHAN_CNT];
    logic [7:0] pin_wake_enable;
    logic [15:0] peripheral_wake_enable;
    logic [NMPW_ST_W-1:0] irq_status;
    logic [NMPW_ST_W-1:0] irq_mask;
    logic [NMPW_PIN_VEC_W-1:0] pin_meta;
    logic [NMPW_PIN_VEC_W-1:0] pin_sync;
    logic [31:0] sel_off;
    logic [2:0] sel_idx;
    logic sel_hit;
    logic [7:0] next_pin_chan;
    logic [31:0] next_core_irq;
    logic next_nmi;
    logic next_wake_req;
    logic [NMPW_ST_W-1:0] next_events;
    logic [31:0] next_rdata;

    // selector index from the byte address
    assign sel_off = i_reg_addr - NMPW_PIN_SEL0_ADDR;
    assign sel_idx = sel_off[4:2];
    assign sel_hit = nmpw_sel_hit(i_reg_addr);

    // ------------------------------------------------------------------
    // pin synchroniser
    // ------------------------------------------------------------------

    // pins are asynchronous; bit 31 has no pin and stays low
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            pin_meta <= '0;
            pin_sync <= '0;
        end else begin
            pin_meta <= {1'b0, i_pin_in};
            pin_sync <= pin_meta;
        end
    end

    // ------------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------------

    // nmi source: change order is the software's job, no interlock here
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            nmi_irq_number <= NMPW_NMI_IRQ_NUMBER_RST;
            nmi_route_enable <= NMPW_NMI_EN_RST;
        end else if (i_reg_wr && i_reg_addr == NMPW_NMI_SRC_ADDR) begin
            nmi_irq_number <= i_reg_wdata[NMPW_NMI_IRQ_NUMBER_W-1:0];
            nmi_route_enable <= i_reg_wdata[NMPW_NMI_EN_BIT];
        end
    end

    // eight selectors; invalid numbers are stored but select nothing
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            for (int k = 0; k < NMPW_CHAN_CNT; k++) begin
                pin_irq_select[k] <= NMPW_PIN_SEL_RST;
            end
        end else if (i_reg_wr && sel_hit) begin
            pin_irq_select[sel_idx] <= i_reg_wdata[NMPW_PIN_NUM_W-1:0];
        end
    end

    // wake enables; unmapped peripheral bits cannot be set
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            pin_wake_enable <= NMPW_PIN_WAKE_RST;
            peripheral_wake_enable <= NMPW_PERI_WAKE_RST;
        end else begin
            if (i_reg_wr && i_reg_addr == NMPW_PIN_WAKE_ADDR) begin
                pin_wake_enable <= i_reg_wdata[7:0] & NMPW_PIN_WAKE_MASK;
            end
            if (i_reg_wr && i_reg_addr == NMPW_PERI_WAKE_ADDR) begin
                peripheral_wake_enable <= i_reg_wdata[15:0] & NMPW_PERI_WAKE_MASK;
            end
        end
    end

    // interrupt mask
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            irq_mask <= NMPW_ST_RST;
        end else if (i_reg_wr && i_reg_addr == NMPW_IRQ_MASK_ADDR) begin
            irq_mask <= i_reg_wdata[NMPW_ST_W-1:0];
        end
    end

    // ------------------------------------------------------------------
    // routing
    // ------------------------------------------------------------------

    // selector picks the physical pin, whatever function the matrix gave it
    always_comb begin
        next_pin_chan = '0;
        for (int k = 0; k < NMPW_CHAN_CNT; k++) begin
            if (nmpw_pin_ok(pin_irq_select[k])) begin
                next_pin_chan[k] = pin_sync[pin_irq_select[k][4:0]];
            end
        end
    end

    // normal requests 0..23 pass untouched; pin channels take slots 24..31 in place of theirs
    always_comb begin
        next_core_irq = i_periph_irq;
        for (int k = 0; k < NMPW_CHAN_CNT; k++) begin
            next_core_irq[NMPW_PIN_SLOT_BASE+k] = o_pin_chan[k];
        end
    end

    // the nmi copy does not suppress the normal request
    assign next_nmi = nmi_route_enable && next_core_irq[nmi_irq_number];

    // wake only while asleep, from any enabled source
    assign next_wake_req = i_deep_sleep
        && ((|(pin_wake_enable & o_pin_chan))
        || (|(peripheral_wake_enable & i_wake_src)));

    // all routed outputs registered on the same edge; the pin slots of o_core_irq trail o_pin_chan by one edge
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            o_pin_chan <= '0;
            o_core_irq <= '0;
            o_nmi <= 1'b0;
            o_wake_req <= 1'b0;
        end else begin
            o_pin_chan <= next_pin_chan;
            o_core_irq <= next_core_irq;
            o_nmi <= next_nmi;
            o_wake_req <= next_wake_req;
        end
    end

    // ------------------------------------------------------------------
    // event status and interrupt
    // ------------------------------------------------------------------

    // rising nmi, rising wake, and a write of a pin number that does not exist
    always_comb begin
        next_events = '0;
        next_events[NMPW_ST_NMI] = next_nmi && !o_nmi;
        next_events[NMPW_ST_WAKE] = next_wake_req && !o_wake_req;
        next_events[NMPW_ST_BADPIN] = i_reg_wr && sel_hit
            && !nmpw_pin_ok(i_reg_wdata[5:0]);
    end

    // write one to clear; a new event in the same cycle wins
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            irq_status <= NMPW_ST_RST;
        end else if (i_reg_wr && i_reg_addr == NMPW_IRQ_STAT_ADDR) begin
            irq_status <= (irq_status & ~i_reg_wdata[NMPW_ST_W-1:0]) | next_events;
        end else begin
            irq_status <= irq_status | next_events;
        end
    end

    // level interrupt from unmasked sticky bits
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= |(irq_status & irq_mask);
        end
    end

    // ------------------------------------------------------------------
    // read path
    // ------------------------------------------------------------------

    // reserved bits and unmapped addresses read as zero
    always_comb begin
        next_rdata = '0;
        if (sel_hit) begin
            next_rdata[NMPW_PIN_NUM_W-1:0] = pin_irq_select[sel_idx];
        end else begin
            case (i_reg_addr)
                NMPW_NMI_SRC_ADDR: begin
                    next_rdata[NMPW_NMI_IRQ_NUMBER_W-1:0] = nmi_irq_number;
                    next_rdata[NMPW_NMI_EN_BIT] = nmi_route_enable;
                end
                NMPW_PIN_WAKE_ADDR: next_rdata[7:0] = pin_wake_enable;
                NMPW_PERI_WAKE_ADDR: next_rdata[15:0] = peripheral_wake_enable;
                NMPW_IRQ_STAT_ADDR: next_rdata[NMPW_ST_W-1:0] = irq_status;
                NMPW_IRQ_MASK_ADDR: next_rdata[NMPW_ST_W-1:0] = irq_mask;
                NMPW_LIVE_ADDR: next_rdata[9:0] = {o_wake_req, o_nmi, o_pin_chan};
                default: next_rdata = '0;
            endcase
        end
    end

    // data stands only in the cycle after the read strobe
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            o_reg_rdata <= '0;
        end else begin
            o_reg_rdata <= i_reg_rd ? next_rdata : 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking nmpw_cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_rst_n);

    // ------------------------------------------------------------------
    // nmi source checks
    // ------------------------------------------------------------------

    // the nmi copy must follow the request it was pointed at
    nmi_route_a: assert property (o_nmi |-> o_core_irq[$past(nmi_irq_number)])
        else $error("nmi raised without its selected request");

    // a cleared enable keeps the nmi line quiet
    nmi_gate_a: assert property (!$past(nmi_route_enable) |-> !o_nmi)
        else $error("nmi raised while routing disabled");

    // one event, two requests, both on the same edge
    nmi_dual_a: assert property ($past(nmi_route_enable)
        && o_core_irq[$past(nmi_irq_number)] |-> o_nmi)
        else $error("selected request did not also raise nmi");

    // a source write lands on the edge that takes it
    nmi_write_a: assert property ($past(i_reg_wr && i_reg_addr == NMPW_NMI_SRC_ADDR)
        |-> nmi_irq_number == $past(i_reg_wdata[NMPW_NMI_IRQ_NUMBER_W-1:0])
        && nmi_route_enable == $past(i_reg_wdata[NMPW_NMI_EN_BIT]))
        else $error("nmi source write did not land");

    // no interlock, so nothing but a write may move the source
    nmi_hold_a: assert property (!$past(i_reg_wr && i_reg_addr == NMPW_NMI_SRC_ADDR)
        |-> $stable(nmi_irq_number) && $stable(nmi_route_enable))
        else $error("nmi source changed without a write");

    // read data of the source register carry both fields
    rdata_nmi_a: assert property ($past(i_reg_rd && i_reg_addr == NMPW_NMI_SRC_ADDR)
        |-> o_reg_rdata == {$past(nmi_route_enable), 26'h000_0000, $past(nmi_irq_number)})
        else $error("nmi source read back wrong");

    // ------------------------------------------------------------------
    // pin selector checks
    // ------------------------------------------------------------------

    // a number with no pin behind it must leave the channel low
    pin_bad_a: assert property (!nmpw_pin_ok($past(pin_irq_select[0]))
        |-> !o_pin_chan[0])
        else $error("invalid pin number drove channel 0");

    // three flops from pin to channel: two sync stages and the output
    pin_sample_a: assert property ((pin_irq_select[0] == 6'h05) [*4]
        |-> o_pin_chan[0] == $past(i_pin_in[5], 3))
        else $error("channel 0 does not follow pin five");

    // channels reach the core one edge after they settle
    pin_slot_a: assert property (o_core_irq[31:24] == $past(o_pin_chan))
        else $error("pin channels missing from slots 24 to 31");

    // selector writes are stored even when the number is invalid
    pin_write_a: assert property ($past(i_reg_wr && sel_hit)
        |-> pin_irq_select[$past(sel_idx)] == $past(i_reg_wdata[NMPW_PIN_NUM_W-1:0]))
        else $error("pin selector write did not land");

    // software learns of a bad number through the status bit
    pin_flag_a: assert property (i_reg_wr && sel_hit
        && !nmpw_pin_ok(i_reg_wdata[NMPW_PIN_NUM_W-1:0]) |=> irq_status[NMPW_ST_BADPIN])
        else $error("invalid pin write did not flag");

    // ------------------------------------------------------------------
    // wake checks
    // ------------------------------------------------------------------

    // an enabled pin channel wakes the chip one edge later
    wake_pin_a: assert property ($past(i_deep_sleep && |(pin_wake_enable & o_pin_chan))
        |-> o_wake_req)
        else $error("enabled pin channel did not wake");

    // pin wake enables take the written byte
    wake_write_a: assert property ($past(i_reg_wr && i_reg_addr == NMPW_PIN_WAKE_ADDR)
        |-> pin_wake_enable == $past(i_reg_wdata[7:0]))
        else $error("pin wake enable write did not land");

    // no pin channel may wake the chip straight out of reset
    wake_reset_a: assert property ($past(!i_rst_n) |-> pin_wake_enable == 8'h00)
        else $error("pin wake enables not cleared by reset");

    // reserved peripheral positions can never hold a one
    wake_mask_a: assert property ((peripheral_wake_enable & ~NMPW_PERI_WAKE_MASK) == '0)
        else $error("unmapped peripheral wake bit set");

    // an enabled peripheral source wakes the chip one edge later
    wake_peri_a: assert property ($past(i_deep_sleep)
        && $past(|(peripheral_wake_enable & i_wake_src)) |-> o_wake_req)
        else $error("enabled peripheral source did not wake");

    // disabled sources must not wake the chip
    wake_quiet_a: assert property ($past(i_deep_sleep)
        && !$past(|(pin_wake_enable & o_pin_chan))
        && !$past(|(peripheral_wake_enable & i_wake_src)) |-> !o_wake_req)
        else $error("wake request without an enabled source");

    // the request is for the power controller only while asleep
    wake_awake_a: assert property (!$past(i_deep_sleep) |-> !o_wake_req)
        else $error("wake request raised while awake");

    // ------------------------------------------------------------------
    // status and bus checks
    // ------------------------------------------------------------------

    // set wins over a same-cycle clear, so no event is lost
    stat_set_a: assert property (|next_events
        |=> (irq_status & $past(next_events)) == $past(next_events))
        else $error("event did not set its status bit");

    // the line lags the masked status by one edge
    irq_level_a: assert property (o_irq == |($past(irq_status & irq_mask)))
        else $error("interrupt line disagrees with masked status");

    // read data stand only in the cycle after the strobe
    rdata_idle_a: assert property (!$past(i_reg_rd) |-> o_reg_rdata == 32'h0000_0000)
        else $error("read data outside the read cycle");

    // main scenarios
    nmi_seen_c: cover property (o_nmi && o_core_irq[$past(nmi_irq_number)]);
    pin_wake_c: cover property ($rose(o_wake_req) && |o_pin_chan);
    peri_wake_c: cover property ($rose(o_wake_req) && |(peripheral_wake_enable & i_wake_src));
    bad_pin_c: cover property ($rose(irq_status[NMPW_ST_BADPIN]) ##1 o_irq);

endmodule
`default_nettype wire

//--- nmpw_pkg.sv
// nmpw_pkg.sv: constants for the nmi, pin interrupt and wake select block
package nmpw_pkg;

    // ------------------------------------------------------------------
    // register byte addresses
    // ------------------------------------------------------------------
    localparam logic [31:0] NMPW_NMI_SRC_ADDR = 32'h4004_8174;
    localparam logic [31:0] NMPW_PIN_SEL0_ADDR = 32'h4004_8178;
    localparam logic [31:0] NMPW_PIN_SEL7_ADDR = 32'h4004_8194;
    localparam logic [31:0] NMPW_PIN_WAKE_ADDR = 32'h4004_8204;
    localparam logic [31:0] NMPW_PERI_WAKE_ADDR = 32'h4004_8214;
    localparam logic [31:0] NMPW_IRQ_STAT_ADDR = 32'h4004_82F0;
    localparam logic [31:0] NMPW_IRQ_MASK_ADDR = 32'h4004_82F4;
    localparam logic [31:0] NMPW_LIVE_ADDR = 32'h4004_82F8;

    // ------------------------------------------------------------------
    // field layout
    // ------------------------------------------------------------------
    localparam int NMPW_NMI_IRQ_NUMBER_W = 5;
    localparam int NMPW_NMI_EN_BIT = 31;
    localparam int NMPW_PIN_NUM_W = 6;
    localparam int NMPW_PIN_VEC_W = 32;
    localparam logic [5:0] NMPW_PIN_HOLE = 6'h06;
    localparam logic [5:0] NMPW_PIN_MAX = 6'h1E;
    localparam int NMPW_CHAN_CNT = 8;
    localparam int NMPW_IRQ_CNT = 32;
    localparam int NMPW_PIN_SLOT_BASE = 24;
    localparam int NMPW_WAKE_SRC_W = 16;
    localparam logic [7:0] NMPW_PIN_WAKE_MASK = 8'hFF;
    // writable peripheral wake bits: 0,3,4,6,7,8,11,12,13,15
    localparam logic [15:0] NMPW_PERI_WAKE_MASK = 16'hB9D9;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [4:0] NMPW_NMI_IRQ_NUMBER_RST = 5'h00;
    localparam logic NMPW_NMI_EN_RST = 1'b0;
    localparam logic [5:0] NMPW_PIN_SEL_RST = 6'h00;
    localparam logic [7:0] NMPW_PIN_WAKE_RST = 8'h00;
    localparam logic [15:0] NMPW_PERI_WAKE_RST = 16'h0000;

    // ------------------------------------------------------------------
    // event status bits
    // ------------------------------------------------------------------
    localparam int NMPW_ST_NMI = 0;
    localparam int NMPW_ST_WAKE = 1;
    localparam int NMPW_ST_BADPIN = 2;
    localparam int NMPW_ST_W = 3;
    localparam logic [2:0] NMPW_ST_RST = 3'h0;

endpackage

//--- nmpw_core_model.sv
// nmpw_core_model.sv: core interrupt sink and power controller facing the block
`timescale 1ns/1ps
`default_nettype none
module nmpw_core_model (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_sleep_cmd,
    input wire logic i_slow,
    input wire logic i_wake_req,
    input wire logic [31:0] i_irq_en,
    input wire logic [31:0] i_core_irq,
    input wire logic i_nmi,
    output logic o_deep_sleep,
    output int o_nmi_cnt,
    output int o_irq_cnt
);
    // ----------------------------------------------------------------
    // sleep state and event counters
    // ----------------------------------------------------------------
    logic wake_seen;
    logic nmi_q;
    logic irq_q;
    // slow mode needs two wake cycles, so a one-cycle glitch is not enough
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            o_deep_sleep <= 1'b0;
            wake_seen <= 1'b0;
        end else begin
            wake_seen <= i_wake_req;
            if (i_sleep_cmd) o_deep_sleep <= 1'b1;
            else if (i_wake_req && (!i_slow || wake_seen)) o_deep_sleep <= 1'b0;
        end
    end
    // only lines that software enabled are serviced as normal requests
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            nmi_q <= 1'b0;
            irq_q <= 1'b0;
            o_nmi_cnt <= 0;
            o_irq_cnt <= 0;
        end else begin
            nmi_q <= i_nmi;
            irq_q <= |(i_core_irq & i_irq_en);
            if (i_nmi && !nmi_q) o_nmi_cnt <= o_nmi_cnt + 1;
            if (|(i_core_irq & i_irq_en) && !irq_q) o_irq_cnt <= o_irq_cnt + 1;
        end
    end
endmodule
`default_nettype wire

//--- tb_top.sv
// tb_top.sv: self-checking bench for the nmi, pin interrupt and wake select block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import nmpw_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [31:0] addr = '0;
    logic [31:0] wdata = '0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [31:0] pirq = '0;
    logic [30:0] pins = '0;
    logic [15:0] wsrc = '0;
    logic sleep_cmd = 1'b0;
    logic slow = 1'b0;
    logic [31:0] irq_en = '0;
    logic [31:0] rdata, core_irq;
    logic nmi, wake, irq, sleep;
    logic [7:0] chan;
    logic [5:0] sel [8];
    logic [31:0] d;
    int nmi_cnt, irq_cnt, n0, i0, n;
    int fails = 0;
    int num_checks = 0;
    int cyc = 0;

    nmpw_top dut (.i_core_clk(clk), .i_rst_n(rst_n), .i_reg_addr(addr), .i_reg_wdata(wdata),
        .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata), .i_periph_irq(pirq),
        .i_pin_in(pins), .i_wake_src(wsrc), .i_deep_sleep(sleep), .o_core_irq(core_irq),
        .o_nmi(nmi), .o_pin_chan(chan), .o_wake_req(wake), .o_irq(irq));
    nmpw_core_model core (.i_core_clk(clk), .i_rst_n(rst_n), .i_sleep_cmd(sleep_cmd),
        .i_slow(slow), .i_wake_req(wake), .i_irq_en(irq_en), .i_core_irq(core_irq),
        .i_nmi(nmi), .o_deep_sleep(sleep), .o_nmi_cnt(nmi_cnt), .o_irq_cnt(irq_cnt));

    // free-running clock, plus a ceiling well above the expected run length
    initial begin
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 8000) begin
            fails++;
            end_of_test();
        end
    end

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            fails++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wrr(input logic [31:0] a, input logic [31:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // read data are valid only in the cycle after the strobe
    task automatic rdc(input logic [31:0] a, input logic [31:0] e, input string nm);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(nm, e, rdata);
    endtask
    task automatic wt(input int c);
        repeat (c) @(posedge clk);
        #1;
    endtask
    task automatic nap;
        @(posedge clk);
        sleep_cmd <= 1'b1;
        @(posedge clk);
        sleep_cmd <= 1'b0;
    endtask
    function automatic logic [31:0] ra(input int i);
        if (i == 0) return NMPW_NMI_SRC_ADDR;
        if (i < 9) return NMPW_PIN_SEL0_ADDR + 32'(4 * (i - 1));
        return (i == 9) ? NMPW_PIN_WAKE_ADDR : NMPW_PERI_WAKE_ADDR;
    endfunction
    function automatic logic [31:0] rm(input int i);
        if (i == 0) return 32'h8000_001F;
        if (i < 9) return 32'h0000_003F;
        return (i == 9) ? 32'h0000_00FF : {16'h0000, NMPW_PERI_WAKE_MASK};
    endfunction
    // invalid selector values route nothing to their channel
    function automatic logic [7:0] xchan(input logic [30:0] p);
        xchan = '0;
        for (int k = 0; k < 8; k++) if (sel[k] != 6'h06 && sel[k] <= 6'h1E) xchan[k] = p[sel[k]];
    endfunction

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        void'($urandom(32'hc8a78a84));
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 11; i++) rdc(ra(i), 32'h0000_0000, "reset value");
        for (int i = 0; i < 11; i++) begin
            d = $urandom;
            wrr(ra(i), d);
            rdc(ra(i), d & rm(i), "readback");
        end
        wrr(32'h4004_8170, 32'hFFFF_FFFF);
        rdc(32'h4004_8170, 32'h0000_0000, "unmapped");
        rdc(32'h4004_8179, 32'h0000_0000, "unaligned");
        for (int i = 0; i < 11; i++) wrr(ra(i), 32'h0000_0000);
        wrr(NMPW_IRQ_STAT_ADDR, 32'h0000_0007);
        // invalid pin number raises the status bit, mask gates the line
        wrr(NMPW_IRQ_MASK_ADDR, 32'h0000_0004);
        wrr(NMPW_PIN_SEL0_ADDR, 32'h0000_0006);
        wt(2);
        chk("irq", 1, irq);
        rdc(NMPW_IRQ_STAT_ADDR, 32'h0000_0004, "status");
        wrr(NMPW_IRQ_STAT_ADDR, 32'h0000_0004);
        wt(2);
        chk("irq", 0, irq);
        wrr(NMPW_IRQ_MASK_ADDR, 32'h0000_0000);
        wrr(NMPW_PIN_SEL0_ADDR, 32'h0000_003F);
        wt(2);
        chk("irq", 0, irq);
        rdc(NMPW_IRQ_STAT_ADDR, 32'h0000_0004, "status");
        // pin selectors with boundary pins and the missing pin
        for (int r = 0; r < 3; r++) begin
            for (int k = 0; k < 8; k++) begin
                sel[k] = 6'($urandom_range(30, 0));
                if (sel[k] == 6'h06) sel[k] = 6'h07;
                if (k == 0) sel[k] = (r == 1) ? 6'h05 : 6'h00;
                if (k == 7) sel[k] = 6'h1E;
                if (k == 3 && r == 2) sel[k] = 6'h06;
                wrr(ra(k + 1), {26'h0, sel[k]});
            end
            pins <= 31'($urandom) | 31'h0000_0040;
            wt(6);
            chk("pin chan", {24'h0, xchan(pins)}, {24'h0, chan});
            chk("slots", {24'h0, xchan(pins)}, {24'h0, core_irq[31:24]});
            rdc(NMPW_LIVE_ADDR, {24'h0, xchan(pins)}, "live");
        end
        @(posedge clk);
        pins <= '0;
        // nmi routing, software reprograms in the safe order
        for (int i = 0; i < 6; i++) begin
            n = $urandom_range(23, 0);
            irq_en <= i[0] ? (32'h1 << n) : 32'h0;
            wrr(NMPW_NMI_SRC_ADDR, 32'h0000_0000);
            wrr(NMPW_NMI_SRC_ADDR, 32'(n));
            if (i != 5) wrr(NMPW_NMI_SRC_ADDR, 32'h8000_0000 | 32'(n));
            wt(2);
            n0 = nmi_cnt;
            i0 = irq_cnt;
            @(posedge clk);
            pirq <= 32'h1 << n;
            wt(3);
            chk("nmi", (i != 5), nmi);
            chk("normal line", 1, core_irq[n]);
            chk("nmi count", n0 + (i != 5), nmi_cnt);
            chk("irq count", i0 + i[0], irq_cnt);
            @(posedge clk);
            pirq <= '0;
            wt(3);
        end
        // pin channel 0 wakes the chip
        wrr(NMPW_PIN_WAKE_ADDR, 32'h0000_0001);
        nap();
        wt(4);
        chk("asleep", 1, sleep);
        @(posedge clk);
        pins <= 31'h0000_0001;
        wt(8);
        chk("awake", 0, sleep);
        wrr(NMPW_PIN_WAKE_ADDR, 32'h0000_0000);
        slow <= 1'b1;
        // each writable peripheral source wakes alone, all others stay quiet
        for (int b = 0; b < 16; b++) begin
            if (NMPW_PERI_WAKE_MASK[b]) begin
                wrr(NMPW_PERI_WAKE_ADDR, 32'h1 << b);
                wsrc <= ~(16'h1 << b);
                nap();
                wt(4);
                chk("no wake", 1, sleep);
                @(posedge clk);
                wsrc <= 16'h1 << b;
                wt(6);
                chk("peri wake", 0, sleep);
                @(posedge clk);
                wsrc <= '0;
                wt(2);
            end
        end
        // every event kind has fired by now; one write clears them all
        rdc(NMPW_IRQ_STAT_ADDR, 32'h0000_0007, "status");
        wrr(NMPW_IRQ_STAT_ADDR, 32'h0000_0007);
        rdc(NMPW_IRQ_STAT_ADDR, 32'h0000_0000, "status clear");
        end_of_test();
    end
endmodule
`default_nettype wire
